// ==== core/mpb_top.sv ====
// motor pwm bridge: two modulators, two bridge output controllers, fault flags, apb registers
// What this block does
// R01: sleep high puts controller pins high-impedance
// R02: selects half/full bridge, dual-input or phase/enable
// R03: half bridge: output enable gates, input sets level
// R04: dual-input pair maps coast/reverse/forward/brake
// R05: phase/enable decode with fast or slow decay
// R06: driver feeds modulator to input a, b sets decay
// R07: any fault raises flag, disables both controllers
// R08: one aggregate fault flag per driver supply
// R09: overcurrent raises that supply's overcurrent flag
// R10: deglitch enable per pin pair, retry per pin
// R11: thermal flag follows over-temperature, disables bridges
// R12: 8-bit period counter counts up and wraps
// R13: positive output high until count reaches duty
// R14: negative output inverted with deadband, polarity bits
// R15: duty counter steps up or down by direction
// R16: duty step clock: external, overflow, /2, /8
// R17: 8-bit resolution default, 7-bit option
// R18: duty reaches true fully low and fully high
// R19: modulation starts from configured initial duty
// R20: hold freezes duty, stop also freezes outputs
// R21: continuous wraps duty, boundary-halt stops at extremes
// R22: boundary-halt can switch off modulator oscillator
// R23: period wrap makes one-cycle overflow pulse
// R24: new duty applies only from next period
`timescale 1ns/10ps
`include "mpb_regs.svh"

module mpb_top
    import mpb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // modulator side
    input wire logic [1:0] duty_clk_ext,
    input wire logic [1:0] duty_up,
    input wire logic [1:0] hold,
    output logic [1:0] mod_pos,
    output logic [1:0] mod_neg,
    output logic [1:0] boundary_oscillator_gate,
    // bridge output controller side
    input wire logic [1:0] sleep,
    input wire logic [1:0] drive_enable,
    input wire logic [1:0] bridge_input_a,
    input wire logic [1:0] bridge_input_b,
    input wire logic [1:0] phase_direction_input,
    output logic [3:0] pin_level,
    output logic [3:0] pin_oe_n,
    // fault side
    input wire logic [3:0] overcurrent,
    input wire logic [1:0] undervoltage,
    input wire logic over_temp,
    output logic [1:0] fault_flag,
    output logic [1:0] overcurrent_fault_flag,
    output logic thermal_fault_flag
);
    // register file
    mpb_mod_cfg_type mod_cfg [2]; // modulator configuration
    logic [31:0] bridge_cfg; // bridge modes
    logic [31:0] fault_cfg; // deglitch, retry and uvlo enables
    // modulator state, one entry per unit
    logic [7:0] period_counter [2];
    logic [7:0] duty_counter [2];
    logic [7:0] act_duty [2]; // duty in force for the running period
    logic [7:0] db_cnt [2]; // deadband timer
    logic [2:0] ovf_div [2]; // overflow prescaler
    logic [1:0] ext_prev; // last external duty clock level
    logic [1:0] en_q; // enable a cycle late so a new initial duty loads first
    logic [1:0] halted; // boundary-halt reached
    // fault state, one entry per pin, plus the block-wide any_fault
    logic [7:0] degl_cnt [4];
    logic [9:0] retry_cnt [4];
    logic [3:0] pin_fault;
    logic any_fault;
    // apb decode
    wire access = psel & penable & ~pready;
    wire wr_take = psel & penable & pready & pwrite;
    wire hit_m0 = paddr == `MPB_MOD0_CFG_OFS;
    wire hit_m1 = paddr == `MPB_MOD1_CFG_OFS;
    wire hit_br = paddr == `MPB_BRIDGE_CFG_OFS;
    wire hit_fc = paddr == `MPB_FAULT_CFG_OFS;
    wire hit_st = paddr == `MPB_STATUS_OFS;
    wire hit_du = paddr == `MPB_DUTY_OFS;
    wire mapped = hit_m0 | hit_m1 | hit_br | hit_fc | hit_st | hit_du;
    wire [31:0] status_word = {19'h0, pin_fault, boundary_oscillator_gate, halted,
                               thermal_fault_flag, overcurrent_fault_flag, fault_flag};
    wire [31:0] duty_word = {16'h0, act_duty[1], act_duty[0]};
    wire [31:0] rd_mux = hit_m0 ? mod_cfg[0] :
                         hit_m1 ? mod_cfg[1] :
                         hit_br ? bridge_cfg :
                         hit_fc ? fault_cfg :
                         hit_st ? status_word :
                         hit_du ? duty_word : 32'h0000_0000;

    // apb answer: pready rises one cycle into the access phase, read data with it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= access;
            pslverr <= access & ~mapped;
            prdata <= (access & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // register writes land on the edge where pready is sampled high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mod_cfg[0] <= `MPB_MOD_CFG_RST;
            mod_cfg[1] <= `MPB_MOD_CFG_RST;
            bridge_cfg <= `MPB_BRIDGE_CFG_RST;
            fault_cfg <= `MPB_FAULT_CFG_RST;
        end
        else if (ce && wr_take)
        begin
            if (hit_m0)
                mod_cfg[0] <= pwdata;
            if (hit_m1)
                mod_cfg[1] <= pwdata;
            if (hit_br)
                bridge_cfg <= pwdata;
            if (hit_fc)
                fault_cfg <= pwdata;
        end
    end

    // the two modulator units
    genvar m;
    generate
        for (m = 0; m < 2; m++)
        begin : g_mod
            // R17: 7-bit resolution halves the period
            wire [7:0] full = mod_cfg[m].res7 ? `MPB_FULL7 : `MPB_FULL8;
            wire en = mod_cfg[m].enable & en_q[m];
            // stop freezes the whole unit, keep only the duty value
            wire stop_hold = hold[m] & mod_cfg[m].stop_sel;
            wire run = en & ~stop_hold & ~boundary_oscillator_gate[m];
            // R23: overflow pulse on wrap
            wire ovf = run & (period_counter[m] == full);
            wire ext_rise = duty_clk_ext[m] & ~ext_prev[m];
            // R16: duty step clock select
            wire step_src = (mod_cfg[m].dclk == MPB_DCLK_EXT) ? ext_rise :
                            (mod_cfg[m].dclk == MPB_DCLK_OVF) ? ovf :
                            (mod_cfg[m].dclk == MPB_DCLK_OVF2) ? ovf & ovf_div[m][0] :
                            ovf & (ovf_div[m] == 3'h7);
            // R20: hold blocks stepping in both keep and stop
            wire step = en & step_src & ~hold[m] & ~halted[m];
            // R15: up wraps past full, down wraps below zero (R21 continuous)
            wire [7:0] stepped = duty_up[m] ?
                                 ((duty_counter[m] >= full) ? 8'h00 : duty_counter[m] + 8'h01) :
                                 ((duty_counter[m] == 8'h00) ? full : duty_counter[m] - 8'h01);
            wire at_edge = (duty_counter[m] == 8'h00) | (duty_counter[m] == full);
            // R13: high until count reaches duty; R18: full duty never drops
            wire pos_raw = (act_duty[m] >= full) | (period_counter[m] < act_duty[m]);
            // R14: negative side waits out the deadband after positive falls
            wire neg_raw = ~pos_raw & (db_cnt[m] >= mod_cfg[m].deadband);
            // period counter, prescaler and duty register
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    period_counter[m] <= 8'h00;
                    ovf_div[m] <= 3'h0;
                    act_duty[m] <= 8'h00;
                    ext_prev[m] <= 1'b0;
                    en_q[m] <= 1'b0;
                end
                else if (ce)
                begin
                    ext_prev[m] <= duty_clk_ext[m];
                    en_q[m] <= mod_cfg[m].enable;
                    if (!en)
                    begin
                        // R19: idle unit restarts from the initial duty
                        period_counter[m] <= 8'h00;
                        ovf_div[m] <= 3'h0;
                        act_duty[m] <= mod_cfg[m].init_duty & full;
                    end
                    else if (run)
                    begin
                        // R12: count up to the top and wrap
                        period_counter[m] <= ovf ? 8'h00 : period_counter[m] + 8'h01;
                        if (ovf)
                        begin
                            ovf_div[m] <= ovf_div[m] + 3'h1;
                            // R24: duty changes only at a period boundary
                            act_duty[m] <= duty_counter[m];
                        end
                    end
                end
            end
            // duty counter and boundary-halt state
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    duty_counter[m] <= 8'h00;
                    halted[m] <= 1'b0;
                    boundary_oscillator_gate[m] <= 1'b0;
                end
                else if (ce)
                begin
                    if (!en)
                    begin
                        // R19: load initial duty
                        duty_counter[m] <= mod_cfg[m].init_duty & full;
                        halted[m] <= 1'b0;
                        boundary_oscillator_gate[m] <= 1'b0;
                    end
                    else
                    begin
                        // R15: step the duty of the next period
                        if (step)
                            duty_counter[m] <= stepped;
                        // R21: boundary-halt stops at either extreme
                        halted[m] <= mod_cfg[m].autostop & at_edge;
                        // R22: gate the oscillator once the extreme is in force
                        boundary_oscillator_gate[m] <= halted[m] & mod_cfg[m].osc_gate &
                                                       (act_duty[m] == duty_counter[m]);
                    end
                end
            end
            // output stage; stop hold keeps both levels as they are
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    db_cnt[m] <= 8'h00;
                    mod_pos[m] <= 1'b0;
                    mod_neg[m] <= 1'b0;
                end
                else if (ce)
                begin
                    if (!en)
                    begin
                        db_cnt[m] <= 8'h00;
                        mod_pos[m] <= mod_cfg[m].inv_pos;
                        mod_neg[m] <= mod_cfg[m].inv_neg;
                    end
                    // R20: stop freezes both outputs
                    else if (!stop_hold)
                    begin
                        // deadband timer saturates so it cannot wrap back to zero
                        db_cnt[m] <= pos_raw ? 8'h00 :
                                     (db_cnt[m] == 8'hFF) ? db_cnt[m] : db_cnt[m] + 8'h01;
                        // R14: independent polarity inversion
                        mod_pos[m] <= pos_raw ^ mod_cfg[m].inv_pos;
                        mod_neg[m] <= neg_raw ^ mod_cfg[m].inv_neg;
                    end
                end
            end
        end
    endgenerate

    // per-pin overcurrent deglitch and retry
    genvar p;
    generate
        for (p = 0; p < 4; p++)
        begin : g_pin
            // R10: deglitch enable shared by each pin pair
            wire degl_en = fault_cfg[`MPB_FC_DEGL + p / 2];
            // R10: retry interval selected per pin
            wire [1:0] rsel = fault_cfg[`MPB_FC_RETRY + 2 * p +: 2];
            wire [9:0] retry_len = (rsel == 2'h0) ? 10'(`MPB_RETRY_CYC(`MPB_RETRY0_US)) :
                                   (rsel == 2'h1) ? 10'(`MPB_RETRY_CYC(`MPB_RETRY1_US)) :
                                   (rsel == 2'h2) ? 10'(`MPB_RETRY_CYC(`MPB_RETRY2_US)) :
                                   10'(`MPB_RETRY_CYC(`MPB_RETRY3_US));
            wire seen = overcurrent[p] &
                        (~degl_en | (degl_cnt[p] >= 8'(`MPB_DEGLITCH_CYC - 1)));
            // a latched fault holds for the retry time, then clears once the cause is gone
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    degl_cnt[p] <= 8'h00;
                    retry_cnt[p] <= 10'h000;
                    pin_fault[p] <= 1'b0;
                end
                else if (ce)
                begin
                    degl_cnt[p] <= ~overcurrent[p] ? 8'h00 :
                                   (degl_cnt[p] == 8'hFF) ? degl_cnt[p] : degl_cnt[p] + 8'h01;
                    // R09: detection sets the pin fault, and wins over release
                    if (seen)
                    begin
                        pin_fault[p] <= 1'b1;
                        retry_cnt[p] <= retry_len;
                    end
                    else if (retry_cnt[p] != 10'h000)
                        retry_cnt[p] <= retry_cnt[p] - 10'h001;
                    else
                        pin_fault[p] <= 1'b0;
                end
            end
        end
    endgenerate
    // supply a owns pins 0 and 1, supply b pins 2 and 3
    wire [1:0] next_ocf = {pin_fault[3] | pin_fault[2], pin_fault[1] | pin_fault[0]};
    wire [1:0] uvlo = undervoltage & fault_cfg[`MPB_FC_UVLO_EN +: 2];

    // fault flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overcurrent_fault_flag <= 2'h0;
            thermal_fault_flag <= 1'b0;
            fault_flag <= 2'h0;
            any_fault <= 1'b0;
        end
        else if (ce)
        begin
            // R09: overcurrent flag per supply
            overcurrent_fault_flag <= next_ocf;
            // R11: thermal flag follows the over-temperature level
            thermal_fault_flag <= over_temp;
            // R08: each supply flag ORs its own sources plus die temperature
            fault_flag <= next_ocf | uvlo | {2{over_temp}};
            // R07: any fault disables both controllers, releases on its own
            any_fault <= (|next_ocf) | (|uvlo) | over_temp;
        end
    end

    // bridge decode of one controller
    function automatic mpb_bridge_type bridge_decode(input logic full, input logic phen,
        input logic slow, input logic oe, input logic ina, input logic inb, input logic ph);
        mpb_bridge_type r;
        r = '0;
        // R02: mode selection
        if (!full)
        begin
            // R03: half bridge, each pin from its own input
            r.first = '{drive: oe, level: oe & ina};
            r.second = '{drive: oe, level: oe & inb};
        end
        else if (!phen)
        begin
            // R04: dual-input decode; R06: b low gives fast decay with pwm on a
            r.first = '{drive: ina | inb, level: ina & ~inb};
            r.second = '{drive: ina | inb, level: inb & ~ina};
        end
        else
        begin
            // R05: phase/enable decode, decay applies while enable is low
            r.first = '{drive: oe | slow, level: oe & ~ph};
            r.second = '{drive: oe | slow, level: oe & ph};
        end
        return r;
    endfunction

    // bridge output controllers; pins registered so every output leaves a flop
    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : g_br
            wire [3:0] bf = bridge_cfg[`MPB_BR_STRIDE * c +: 4];
            wire mpb_bridge_type dec = bridge_decode(bf[`MPB_BR_FULL], bf[`MPB_BR_PHEN],
                bf[`MPB_BR_SLOW], drive_enable[c], bridge_input_a[c], bridge_input_b[c],
                phase_direction_input[c]);
            // R01: sleep alone releases this controller; R07: faults release both
            wire live = ~sleep[c] & ~any_fault;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_oe_n[2 * c +: 2] <= 2'h3;
                    pin_level[2 * c +: 2] <= 2'h0;
                end
                else if (ce)
                begin
                    // R01: high-impedance while asleep
                    pin_oe_n[2 * c] <= ~(live & dec.first.drive);
                    pin_oe_n[2 * c + 1] <= ~(live & dec.second.drive);
                    pin_level[2 * c] <= live & dec.first.level;
                    pin_level[2 * c + 1] <= live & dec.second.level;
                end
            end
        end
    endgenerate
endmodule // mpb_top

// ==== core/mpb_regs.svh ====
// register offsets, field positions, reset values and timing counts of the motor pwm bridge
`ifndef MPB_REGS_SVH
`define MPB_REGS_SVH

// register byte offsets
`define MPB_MOD0_CFG_OFS 8'h00
`define MPB_MOD1_CFG_OFS 8'h04
`define MPB_BRIDGE_CFG_OFS 8'h08
`define MPB_FAULT_CFG_OFS 8'h0C
`define MPB_STATUS_OFS 8'h10
`define MPB_DUTY_OFS 8'h14

// reset values
`define MPB_MOD_CFG_RST 32'h0000_0000
`define MPB_BRIDGE_CFG_RST 32'h0000_0000
`define MPB_FAULT_CFG_RST 32'h0000_0000

// bridge config: one nibble per controller
`define MPB_BR_STRIDE 4
`define MPB_BR_FULL 0
`define MPB_BR_PHEN 1
`define MPB_BR_SLOW 2

// fault config fields
`define MPB_FC_DEGL 0
`define MPB_FC_RETRY 2
`define MPB_FC_UVLO_EN 10

// status fields
`define MPB_ST_FAULT 0
`define MPB_ST_OCF 2
`define MPB_ST_THERM 4
`define MPB_ST_HALT 5
`define MPB_ST_OSCOFF 7
`define MPB_ST_PINF 9

// modulator range limits
`define MPB_FULL8 8'hFF
`define MPB_FULL7 8'h7F

// timing: clock rate and the overcurrent figures
`define MPB_CLK_MHZ 125
`define MPB_DEGLITCH_NS 1000
`define MPB_DEGLITCH_CYC ((`MPB_DEGLITCH_NS * `MPB_CLK_MHZ + 999) / 1000)
`define MPB_RETRY0_US 1
`define MPB_RETRY1_US 2
`define MPB_RETRY2_US 4
`define MPB_RETRY3_US 8
`define MPB_RETRY_CYC(us) ((us) * `MPB_CLK_MHZ)

`endif

// ==== core/mpb_pkg.sv ====
// types shared by the motor pwm bridge block
package mpb_pkg;

    // source of the duty-step clock
    typedef enum logic [1:0] {
        MPB_DCLK_EXT,
        MPB_DCLK_OVF,
        MPB_DCLK_OVF2,
        MPB_DCLK_OVF8
    } mpb_dclk_type;

    // modulator configuration word, exactly one 32-bit register
    typedef struct packed {
        logic [7:0] deadband;
        logic [7:0] init_duty;
        logic [6:0] spare;
        logic inv_neg;
        logic inv_pos;
        logic osc_gate;
        logic autostop;
        logic stop_sel;
        logic res7;
        mpb_dclk_type dclk;
        logic enable;
    } mpb_mod_cfg_type;

    // drive state of one output pin
    typedef struct packed {
        logic drive;
        logic level;
    } mpb_pin_type;

    // both pins of one bridge output controller
    typedef struct packed {
        mpb_pin_type first;
        mpb_pin_type second;
    } mpb_bridge_type;

endpackage

// ==== tb/mpb_top_monitor.sv ====
// port checker for the motor pwm bridge
`timescale 1ns/10ps

module mpb_top_monitor
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] sleep,
    input wire logic over_temp,
    input wire logic [3:0] overcurrent,
    input wire logic [3:0] pin_oe_n,
    input wire logic [1:0] mod_pos,
    input wire logic [1:0] mod_neg,
    input wire logic [1:0] boundary_oscillator_gate,
    input wire logic [1:0] fault_flag,
    input wire logic [1:0] overcurrent_fault_flag,
    input wire logic thermal_fault_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // heat held past both flag stages
    sequence hot_s;
        over_temp [*4];
    endsequence
    // a short on the third pin, deglitch left off
    sequence short_s;
        overcurrent[2] [*4];
    endsequence
    asleep_first_a: assert property (sleep[0] |=> pin_oe_n[1:0] == 2'b11)
        else $error("first controller drives while asleep");
    asleep_second_a: assert property (sleep[1] |=> pin_oe_n[3:2] == 2'b11)
        else $error("second controller drives while asleep");
    hot_release_a: assert property (hot_s |-> pin_oe_n == 4'hF)
        else $error("pins driven during thermal fault");
    hot_flag_a: assert property (hot_s |-> thermal_fault_flag)
        else $error("thermal flag missing");
    hot_both_a: assert property (hot_s |-> fault_flag == 2'b11)
        else $error("thermal fault not on both supply flags");
    short_flag_a: assert property (short_s |-> overcurrent_fault_flag[1])
        else $error("overcurrent flag missing");
    short_fault_a: assert property (short_s |-> fault_flag[1] && pin_oe_n == 4'hF)
        else $error("overcurrent not reported or pins still driven");
    // no inversion is used, so both high breaks the deadband
    no_overlap_a: assert property (!(|(mod_pos & mod_neg)))
        else $error("both modulator outputs high");
    gate_freeze_a: assert property (boundary_oscillator_gate[0]
        && $past(boundary_oscillator_gate[0]) |-> $stable(mod_pos[0]))
        else $error("output moved with oscillator off");
endmodule // mpb_top_monitor

bind mpb_top mpb_top_monitor i_mpb_top_monitor (.pclk, .presetn, .sleep, .over_temp,
    .overcurrent, .pin_oe_n, .mod_pos, .mod_neg, .boundary_oscillator_gate, .fault_flag,
    .overcurrent_fault_flag, .thermal_fault_flag);

// ==== tb/mpb_motor_model.sv ====
// motor windings seen from the bridge pins
`timescale 1ns/10ps

module mpb_motor_model
(
    input wire logic pclk,
    input wire logic [3:0] pin_level,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] short_cmd,
    output logic [3:0] overcurrent,
    output logic [3:0] pin_wire
);
    // no pull on the pins: a released pin toggles so stale drive never passes
    logic [3:0] float_pat = 4'hA;
    always @(posedge pclk)
        float_pat <= ~float_pat;
    assign pin_wire = (pin_level & ~pin_oe_n) | (float_pat & pin_oe_n);
    // a commanded short shows as overcurrent on that pin
    assign overcurrent = short_cmd;
endmodule // mpb_motor_model

// ==== tb/mpb_top_tb.sv ====
// self-checking bench for the motor pwm bridge
`timescale 1ns/10ps

module mpb_top_tb
    import mpb_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, over_temp, thf;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] dclk, up, hold, sleep, en, ina, inb, ph, uv, pos, neg, gate, ff, ocf;
    logic [3:0] lvl, oen, oc, shrt, wl, e;
    logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int n_fail, n_tests, per, hi;
    mpb_mod_cfg_type cfg;

    mpb_top i_mpb_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .duty_clk_ext(dclk), .duty_up(up), .hold, .mod_pos(pos),
        .mod_neg(neg), .boundary_oscillator_gate(gate), .sleep, .drive_enable(en),
        .bridge_input_a(ina), .bridge_input_b(inb), .phase_direction_input(ph),
        .pin_level(lvl), .pin_oe_n(oen), .overcurrent(oc), .undervoltage(uv), .over_temp,
        .fault_flag(ff), .overcurrent_fault_flag(ocf), .thermal_fault_flag(thf));
    mpb_motor_model i_mpb_motor_model (.pclk, .pin_level(lvl), .pin_oe_n(oen),
        .short_cmd(shrt), .overcurrent(oc), .pin_wire(wl));

    // 125 MHz
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one transfer, begun after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk(32'(k < 20), 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic err;
        apb(1'b1, a, d, q, err);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic err;
        apb(1'b0, a, 32'h0, q, err);
        chk(q, x);
        chk(32'(err), 32'(xe));
    endtask

    // period and high time of the first modulator, rise to rise
    task automatic measure();
        logic prev;
        per = 0;
        prev = 1'b1;
        while (!(pos[0] === 1'b1 && prev === 1'b0) && per < 600)
        begin
            prev = pos[0];
            @(negedge pclk);
            per++;
        end
        per = 0;
        hi = 0;
        do
        begin
            hi += int'(pos[0]);
            per++;
            prev = pos[0];
            @(negedge pclk);
        end
        while (!(pos[0] === 1'b1 && prev === 1'b0) && per < 600);
        @(posedge pclk);
    endtask

    // step the duty counter once by its external clock
    task automatic step(input logic dir, input logic hld);
        up[0] <= dir;
        hold[0] <= hld;
        dclk[0] <= 1'b1;
        cyc(2);
        dclk[0] <= 1'b0;
        measure();
    endtask

    // expected {oe_n second, oe_n first, level second, level first}
    function automatic logic [3:0] bexp(input logic [2:0] m, input logic [2:0] v);
        if (!m[0])
            return v[2] ? {2'b00, v[0], v[1]} : 4'hC;
        if (!m[1])
            return (v[1:0] == 2'b00) ? 4'hC : {2'b00, v[0] & ~v[1], v[1] & ~v[0]};
        if (!v[2])
            return m[2] ? 4'h0 : 4'hC;
        return {2'b00, v[0], ~v[0]};
    endfunction

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, over_temp} = '0;
        {dclk, up, hold, sleep, en, ina, inb, ph, uv, shrt} = '0;
        presetn = 1'b0;
        cyc(8);
        presetn <= 1'b1;
        cyc(1);
        rdc(8'h00, 32'h0, 1'b0);
        rdc(8'h08, 32'h0, 1'b0);
        rdc(8'h0C, 32'h0, 1'b0);
        rdc(8'h18, 32'h0, 1'b1);
        foreach (modes[i])
        begin
            wr(8'h08, {29'h0, modes[i]});
            for (int v = 0; v < 8; v++)
            begin
                en[0] <= v[2];
                ina[0] <= v[1];
                inb[0] <= v[0];
                ph[0] <= v[0];
                cyc(3);
                e = bexp(modes[i], v[2:0]);
                chk({wl[1:0] & ~oen[1:0], oen[1:0]}, {e[1:0], e[3:2]});
            end
        end
        sleep[0] <= 1'b1;
        en[1] <= 1'b1;
        ina[1] <= 1'b1;
        cyc(3);
        chk({oen, wl[3:2]}, {4'h3, 2'b01});
        over_temp <= 1'b1;
        cyc(5);
        chk({thf, ff, oen}, {1'b1, 2'b11, 4'hF});
        over_temp <= 1'b0;
        cyc(6);
        chk({thf, ff, oen[3:2]}, 5'h0);
        shrt <= 4'b0100;
        cyc(5);
        chk({ocf, ff, oen}, {2'b10, 2'b10, 4'hF});
        shrt <= 4'b0000;
        cyc(1100);
        chk({ocf, ff, oen[3:2]}, 6'h0);
        cfg = '0;
        cfg.enable = 1'b1;
        cfg.init_duty = 8'h40;
        wr(8'h00, cfg);
        measure();
        chk(per, 256);
        chk(hi, 64);
        rdc(8'h14, 32'h40, 1'b0);
        step(1'b1, 1'b0);
        chk(hi, 65);
        step(1'b1, 1'b1);
        chk(hi, 65);
        step(1'b0, 1'b0);
        chk(hi, 64);
        cfg.res7 = 1'b1;
        wr(8'h00, cfg);
        measure();
        measure();
        chk(per, 128);
        chk(hi, 64);
        cfg.res7 = 1'b0;
        cfg.init_duty = 8'h00;
        wr(8'h00, 32'h0);
        wr(8'h00, cfg);
        cyc(300);
        chk(pos[0], 0);
        cfg.init_duty = 8'hFF;
        cfg.autostop = 1'b1;
        cfg.osc_gate = 1'b1;
        wr(8'h00, 32'h0);
        wr(8'h00, cfg);
        cyc(600);
        chk({pos[0], gate[0]}, 2'b11);
        end_of_test();
    end

    // the whole run is about 4500 cycles
    initial
    begin
        #200000;
        n_fail++;
        end_of_test();
    end
endmodule // mpb_top_tb
